/* File: shared/pin_mux_consts.svh */
// Register offsets, field positions and reset values of the pin mux
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PM_PLL_SRC_OFF 12'h000
`define PM_CODEC_SRC_OFF 12'h004
`define PM_BCLK_CFG_OFF 12'h008
`define PM_WCLK_CFG_OFF 12'h00c
`define PM_ADC_WCLK_OFF 12'h010
`define PM_GPIO_FUNC_OFF 12'h014
`define PM_GPIO_OUT_OFF 12'h018
`define PM_STATUS_OFF 12'h01c

// ----------------------------------------------------------------
// Field widths and reset values
// ----------------------------------------------------------------
`define PM_SEL_W 2
`define PM_PLL_SRC_RST 2'h0
`define PM_CODEC_SRC_RST 2'h0
`define PM_ADC_WCLK_RST 2'h0
`define PM_GPIO_FUNC_RST 2'h0
`define PM_DIR_RST 1'h0

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define PM_ST_SPI 0
`define PM_ST_GPIO_CLK_DENIED 1
`define PM_ST_SIN_TAKEN 2
`define PM_ST_MDIN_TAKEN 3
`define PM_ST_GPIO_IN 4
`define PM_ST_W 5

`endif

/* File: shared/pin_mux_pkg.sv */
// Types shared by the pin mux modules
`default_nettype none
package pin_mux_pkg;

	// PLL reference pin choice
	typedef enum logic [1:0] {
		PLL_FROM_MCLK = 2'h0,
		PLL_FROM_BCLK = 2'h1,
		PLL_FROM_SIN = 2'h2,
		PLL_FROM_GPIO = 2'h3
	} pll_src_type;

	// Codec clock choice
	typedef enum logic [1:0] {
		CODEC_FROM_MCLK = 2'h0,
		CODEC_FROM_BCLK = 2'h1,
		CODEC_FROM_GPIO = 2'h2,
		CODEC_FROM_PLL = 2'h3
	} codec_src_type;

	// Pin carrying the ADC word clock input
	typedef enum logic [1:0] {
		ADC_WCLK_NONE = 2'h0,
		ADC_WCLK_MDIN = 2'h1,
		ADC_WCLK_GPIO = 2'h2,
		ADC_WCLK_RSVD = 2'h3
	} adc_wclk_pin_type;

	// Function of the general purpose pin
	typedef enum logic [1:0] {
		GPIO_INPUT = 2'h0,
		GPIO_OUTPUT = 2'h1,
		GPIO_INTR = 2'h2,
		GPIO_ADC_WCLK = 2'h3
	} gpio_func_type;

endpackage
`default_nettype wire

/* File: shared/pin_cfg_if.sv */
// Configuration and resolved ownership between register file and resolver
`timescale 1ns/1ps
`default_nettype none
interface pin_cfg_if;
	pin_mux_pkg::pll_src_type pll_src;
	pin_mux_pkg::codec_src_type codec_src;
	pin_mux_pkg::adc_wclk_pin_type adc_wclk_pin;
	pin_mux_pkg::gpio_func_type gpio_func;
	pin_mux_pkg::gpio_func_type gpio_owner;
	logic gpio_clk_ok;
	logic sin_is_pll;
	logic mdin_is_adc_wclk;

	modport regs (
		output pll_src, codec_src, adc_wclk_pin, gpio_func,
		input gpio_owner, gpio_clk_ok, sin_is_pll, mdin_is_adc_wclk
	);
	modport resolve (
		input pll_src, codec_src, adc_wclk_pin, gpio_func,
		output gpio_owner, gpio_clk_ok, sin_is_pll, mdin_is_adc_wclk
	);
endinterface
`default_nettype wire

/* File: rtl/pin_owner_resolve.sv */
// Resolves which function owns each shared pin
`timescale 1ns/1ps
`default_nettype none
module pin_owner_resolve (
	pin_cfg_if.resolve cfg
);

	// ----------------------------------------------------------------
	// General purpose pin ownership
	// ----------------------------------------------------------------
	// ADC word clock owns pin
	always_comb
	begin
		if (cfg.adc_wclk_pin == pin_mux_pkg::ADC_WCLK_GPIO)
			cfg.gpio_owner = pin_mux_pkg::GPIO_ADC_WCLK;
		else if (cfg.gpio_func == pin_mux_pkg::GPIO_ADC_WCLK)
			cfg.gpio_owner = pin_mux_pkg::GPIO_INPUT; // Needs the ADC select
		else
			cfg.gpio_owner = cfg.gpio_func;
	end

	// Clock inputs may share the pin only while it is a plain input
	// clock denied when pin taken
	assign cfg.gpio_clk_ok = (cfg.gpio_owner == pin_mux_pkg::GPIO_INPUT);

	// ----------------------------------------------------------------
	// Exclusive input pins
	// ----------------------------------------------------------------
	// serial input feeds PLL only
	assign cfg.sin_is_pll = (cfg.pll_src == pin_mux_pkg::PLL_FROM_SIN);
	assign cfg.mdin_is_adc_wclk =
		(cfg.adc_wclk_pin == pin_mux_pkg::ADC_WCLK_MDIN);

endmodule // pin_owner_resolve
`default_nettype wire

/* File: rtl/codec_pin_function_mux.sv */
// Pin function multiplexer of the audio codec with APB register access
//
// Behaviour
// - Reset and strap pins never reassignable
// - Strap picks I2C or SPI control bus
// - Pins power up default, software reassigns
// - Other pins selected through registers
// - PLL reference from one of four pins
// - Codec clock from pin or PLL
// - ADC word clock on mic or gpio pin
// - Bit clock pin feeds three functions together
// - Exclusive function owns its pin wholly
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_consts.svh"
module codec_pin_function_mux (
	input wire logic clk_i,
	input wire logic rst_b_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Fixed strap
	input wire logic interface_select_pin_i,
	output logic control_bus_spi_o,
	// Multifunction pins
	input wire logic master_clock_pin_i,
	input wire logic bit_clock_pin_i,
	output logic bit_clock_pin_o,
	output logic bit_clock_pin_oe_o,
	input wire logic word_clock_pin_i,
	output logic word_clock_pin_o,
	output logic word_clock_pin_oe_o,
	input wire logic serial_in_multi_pin_i,
	output logic serial_out_multi_pin_o,
	output logic serial_out_multi_pin_oe_o,
	input wire logic mic_data_multi_pin_i,
	output logic mic_clock_multi_pin_o,
	output logic mic_clock_multi_pin_oe_o,
	input wire logic general_purpose_pin_i,
	output logic general_purpose_pin_o,
	output logic general_purpose_pin_oe_o,
	// Codec core side
	input wire logic pll_clk_i,
	input wire logic core_bclk_i,
	input wire logic core_wclk_i,
	input wire logic core_sdout_i,
	input wire logic core_mic_clk_i,
	input wire logic first_interrupt_output_i,
	output logic pll_ref_o,
	output logic codec_clk_o,
	output logic core_bclk_o,
	output logic core_wclk_o,
	output logic core_sdin_o,
	output logic core_mic_data_o,
	output logic core_adc_wclk_o,
	output logic gpio_in_o
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	localparam int NPIN = 7;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_meta;
	logic [NPIN-1:0] pin_sync;
	logic mclk_s;
	logic bclk_s;
	logic wclk_s;
	logic sin_s;
	logic mdin_s;
	logic gpio_s;
	logic strap_s;

	assign pin_raw = {interface_select_pin_i, general_purpose_pin_i,
		mic_data_multi_pin_i, serial_in_multi_pin_i, word_clock_pin_i,
		bit_clock_pin_i, master_clock_pin_i};

	// Two stages each; only the second stage is read by logic
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++)
		begin : g_sync
			always_ff @(posedge clk_i or negedge rst_b_i)
			begin
				if (!rst_b_i)
				begin
					pin_meta[gi] <= 1'b0;
					pin_sync[gi] <= 1'b0;
				end
				else
				begin
					pin_meta[gi] <= pin_raw[gi];
					pin_sync[gi] <= pin_meta[gi];
				end
			end
		end
	endgenerate

	assign {strap_s, gpio_s, mdin_s, sin_s, wclk_s, bclk_s, mclk_s} =
		pin_sync;

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	pin_cfg_if cfg ();
	logic bclk_out_en;
	logic wclk_out_en;
	logic gpio_out_val;

	pin_owner_resolve u_resolve (
		.cfg(cfg.resolve)
	);

	logic wr_en;
	logic rd_setup;
	logic addr_hit;
	assign wr_en = psel_i && penable_i && pwrite_i && addr_hit;
	assign rd_setup = psel_i && !penable_i && !pwrite_i;

	// Address decode of the mapped words
	always_comb
	begin
		case (paddr_i)
			`PM_PLL_SRC_OFF, `PM_CODEC_SRC_OFF, `PM_BCLK_CFG_OFF,
			`PM_WCLK_CFG_OFF, `PM_ADC_WCLK_OFF, `PM_GPIO_FUNC_OFF,
			`PM_GPIO_OUT_OFF, `PM_STATUS_OFF: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cfg.pll_src <= pin_mux_pkg::pll_src_type'(`PM_PLL_SRC_RST);
			cfg.codec_src <=
				pin_mux_pkg::codec_src_type'(`PM_CODEC_SRC_RST);
			cfg.adc_wclk_pin <=
				pin_mux_pkg::adc_wclk_pin_type'(`PM_ADC_WCLK_RST);
			cfg.gpio_func <=
				pin_mux_pkg::gpio_func_type'(`PM_GPIO_FUNC_RST);
			bclk_out_en <= `PM_DIR_RST;
			wclk_out_en <= `PM_DIR_RST;
			gpio_out_val <= 1'b0;
		end
		else if (wr_en)
		begin
			case (paddr_i)
				`PM_PLL_SRC_OFF: cfg.pll_src <=
					pin_mux_pkg::pll_src_type'(pwdata_i[1:0]);
				`PM_CODEC_SRC_OFF: cfg.codec_src <=
					pin_mux_pkg::codec_src_type'(pwdata_i[1:0]);
				`PM_BCLK_CFG_OFF: bclk_out_en <= pwdata_i[0];
				`PM_WCLK_CFG_OFF: wclk_out_en <= pwdata_i[0];
				`PM_ADC_WCLK_OFF: cfg.adc_wclk_pin <=
					pin_mux_pkg::adc_wclk_pin_type'(pwdata_i[1:0]);
				`PM_GPIO_FUNC_OFF: cfg.gpio_func <=
					pin_mux_pkg::gpio_func_type'(pwdata_i[1:0]);
				`PM_GPIO_OUT_OFF: gpio_out_val <= pwdata_i[0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// APB read path
	// ----------------------------------------------------------------
	logic [`PM_ST_W-1:0] status;
	logic gpio_clk_denied;

	// Clock chosen from the pin while the pin belongs to another function
	assign gpio_clk_denied = !cfg.gpio_clk_ok &&
		(cfg.pll_src == pin_mux_pkg::PLL_FROM_GPIO ||
		cfg.codec_src == pin_mux_pkg::CODEC_FROM_GPIO);

	assign status = {gpio_s, cfg.mdin_is_adc_wclk, cfg.sin_is_pll,
		gpio_clk_denied, strap_s};

	// Data is fetched in the setup cycle so the access cycle ends at once
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			prdata_o <= 32'h0000_0000;
		else if (rd_setup)
		begin
			case (paddr_i)
				`PM_PLL_SRC_OFF: prdata_o <= {30'h0, cfg.pll_src};
				`PM_CODEC_SRC_OFF: prdata_o <= {30'h0, cfg.codec_src};
				`PM_BCLK_CFG_OFF: prdata_o <= {31'h0, bclk_out_en};
				`PM_WCLK_CFG_OFF: prdata_o <= {31'h0, wclk_out_en};
				`PM_ADC_WCLK_OFF: prdata_o <= {30'h0, cfg.adc_wclk_pin};
				`PM_GPIO_FUNC_OFF: prdata_o <= {30'h0, cfg.gpio_func};
				`PM_GPIO_OUT_OFF: prdata_o <= {31'h0, gpio_out_val};
				`PM_STATUS_OFF: prdata_o <= {27'h0, status};
				default: prdata_o <= 32'h0000_0000;
			endcase
		end
	end

	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !addr_hit;

	// ----------------------------------------------------------------
	// Clock and signal routing
	// ----------------------------------------------------------------
	logic gpio_clk;
	logic next_pll_ref;
	logic next_codec_clk;
	// gpio clock gated when pin taken
	assign gpio_clk = gpio_s && cfg.gpio_clk_ok;

	// one of four pins to PLL
	// range is the source's duty, not checked
	always_comb
	begin
		case (cfg.pll_src)
			pin_mux_pkg::PLL_FROM_MCLK: next_pll_ref = mclk_s;
			pin_mux_pkg::PLL_FROM_BCLK: next_pll_ref = bclk_s;
			pin_mux_pkg::PLL_FROM_SIN: next_pll_ref = sin_s;
			pin_mux_pkg::PLL_FROM_GPIO: next_pll_ref = gpio_clk;
			default: next_pll_ref = 1'b0;
		endcase
	end

	// codec clock source, pin or PLL
	// direct pin path has no PLL stage
	always_comb
	begin
		case (cfg.codec_src)
			pin_mux_pkg::CODEC_FROM_MCLK: next_codec_clk = mclk_s;
			pin_mux_pkg::CODEC_FROM_BCLK: next_codec_clk = bclk_s;
			pin_mux_pkg::CODEC_FROM_GPIO: next_codec_clk = gpio_clk;
			pin_mux_pkg::CODEC_FROM_PLL: next_codec_clk = pll_clk_i;
			default: next_codec_clk = 1'b0;
		endcase
	end

	// Outputs toward the codec core
	// exclusive pins feed one function
	// bit clock to core in input mode
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			pll_ref_o <= 1'b0;
			codec_clk_o <= 1'b0;
			core_bclk_o <= 1'b0;
			core_wclk_o <= 1'b0;
			core_sdin_o <= 1'b0;
			core_mic_data_o <= 1'b0;
			core_adc_wclk_o <= 1'b0;
			gpio_in_o <= 1'b0;
		end
		else
		begin
			pll_ref_o <= next_pll_ref;
			codec_clk_o <= next_codec_clk;
			core_bclk_o <= bclk_out_en ? core_bclk_i : bclk_s;
			core_wclk_o <= wclk_out_en ? core_wclk_i : wclk_s;
			core_sdin_o <= sin_s && !cfg.sin_is_pll;
			core_mic_data_o <= mdin_s && !cfg.mdin_is_adc_wclk;
			core_adc_wclk_o <= cfg.mdin_is_adc_wclk ? mdin_s :
				(cfg.gpio_owner == pin_mux_pkg::GPIO_ADC_WCLK) && gpio_s;
			gpio_in_o <= (cfg.gpio_owner == pin_mux_pkg::GPIO_INPUT) &&
				gpio_s;
		end
	end

	// Pin drivers; input functions leave the pin undriven
	// input pins tristated after reset
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			bit_clock_pin_o <= 1'b0;
			bit_clock_pin_oe_o <= 1'b0;
			word_clock_pin_o <= 1'b0;
			word_clock_pin_oe_o <= 1'b0;
			serial_out_multi_pin_o <= 1'b0;
			serial_out_multi_pin_oe_o <= 1'b0;
			mic_clock_multi_pin_o <= 1'b0;
			mic_clock_multi_pin_oe_o <= 1'b0;
			general_purpose_pin_o <= 1'b0;
			general_purpose_pin_oe_o <= 1'b0;
		end
		else
		begin
			bit_clock_pin_o <= bclk_out_en && core_bclk_i;
			bit_clock_pin_oe_o <= bclk_out_en;
			word_clock_pin_o <= wclk_out_en && core_wclk_i;
			word_clock_pin_oe_o <= wclk_out_en;
			serial_out_multi_pin_o <= core_sdout_i;
			serial_out_multi_pin_oe_o <= 1'b1;
			mic_clock_multi_pin_o <= core_mic_clk_i;
			mic_clock_multi_pin_oe_o <= 1'b1;
			case (cfg.gpio_owner)
				pin_mux_pkg::GPIO_OUTPUT:
				begin
					general_purpose_pin_o <= gpio_out_val;
					general_purpose_pin_oe_o <= 1'b1;
				end
				pin_mux_pkg::GPIO_INTR:
				begin
					general_purpose_pin_o <= first_interrupt_output_i;
					general_purpose_pin_oe_o <= 1'b1;
				end
				default:
				begin
					general_purpose_pin_o <= 1'b0;
					general_purpose_pin_oe_o <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Fixed control pins
	// ----------------------------------------------------------------
	// strap has no register path
	assign control_bus_spi_o = strap_s;

endmodule // codec_pin_function_mux
`default_nettype wire

/* File: tb/pin_mux_checker.sv */
// Port assertions of the codec pin function mux, bound to its top
`timescale 1ns/1ps
`default_nettype none
module pin_mux_checker (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pslverr_o,
	input wire logic interface_select_pin_i,
	input wire logic control_bus_spi_o,
	input wire logic master_clock_pin_i,
	input wire logic bit_clock_pin_i,
	input wire logic serial_in_multi_pin_i,
	input wire logic mic_data_multi_pin_i,
	input wire logic general_purpose_pin_i,
	input wire logic pll_ref_o,
	input wire logic codec_clk_o,
	input wire logic core_bclk_o,
	input wire logic bit_clock_pin_oe_o,
	input wire logic core_mic_data_o,
	input wire logic core_adc_wclk_o,
	input wire logic general_purpose_pin_o,
	input wire logic general_purpose_pin_oe_o
);
	logic [1:0] r [0:7];
	logic [1:0] rd [0:7];
	logic [5:0] p1, p2, p3;
	logic [1:0] up;
	wire logic [5:0] pv = {interface_select_pin_i, general_purpose_pin_i,
		mic_data_multi_pin_i, serial_in_multi_pin_i, bit_clock_pin_i,
		master_clock_pin_i};
	// Shadow of the selects; rd lags one edge, as the output flops do
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			r <= '{default: 2'h0};
			rd <= '{default: 2'h0};
			up <= 2'h0;
		end
		else
		begin
			if (psel_i && penable_i && pwrite_i && paddr_i < 12'h01c)
				r[paddr_i[4:2]] <= pwdata_i[1:0];
			rd <= r;
			up <= (up == 2'h3) ? up : up + 2'h1;
		end
	end
	// Pin levels three edges back, the synchroniser plus output delay
	always_ff @(posedge clk_i)
	begin
		p1 <= pv;
		p2 <= p1;
		p3 <= p2;
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	sequence acc_s;
		psel_i && penable_i;
	endsequence
	strap_route_a: assert property (
		up == 2'h3 |-> control_bus_spi_o == p2[5])
		else $error("bus select does not follow strap");
	bus_err_a: assert property (
		acc_s |-> pslverr_o ==
		(paddr_i > 12'h01c || paddr_i[1:0] != 2'h0))
		else $error("slave error wrong for address");
	pll_ref_a: assert property (
		up == 2'h3 && rd[0] != 2'h3 |-> pll_ref_o == p3[rd[0]])
		else $error("PLL reference not from selected pin");
	codec_clk_a: assert property (
		up == 2'h3 && !rd[1][1] |-> codec_clk_o == p3[rd[1]])
		else $error("codec clock not from selected pin");
	bclk_share_a: assert property (
		up == 2'h3 && !rd[2][0] |-> core_bclk_o == p3[1]
		&& !bit_clock_pin_oe_o)
		else $error("bit clock input path broken");
	adc_wclk_a: assert property (
		up == 2'h3 && rd[4] == 2'h1 |-> core_adc_wclk_o == p3[3]
		&& !core_mic_data_o)
		else $error("ADC word clock not from mic data pin");
	gpio_tri_a: assert property (
		rd[4] == 2'h2 || rd[5] == 2'h0 || rd[5] == 2'h3
		|-> !general_purpose_pin_oe_o)
		else $error("input gpio pin is driven");
	gpio_drive_a: assert property (
		rd[4] != 2'h2 && rd[5] == 2'h1 |-> general_purpose_pin_oe_o
		&& general_purpose_pin_o == rd[6][0])
		else $error("gpio output level wrong");
endmodule // pin_mux_checker
bind codec_pin_function_mux pin_mux_checker u_pin_mux_checker (.*);
`default_nettype wire

/* File: tb/pin_partner.sv */
// Model of the clock and data parts wired to the multifunction pins
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
	input wire logic clk_i,
	input wire logic hold_i,
	output logic [5:0] pin_o
);
	logic [9:0] t = 10'h0;
	// Clocks stand still while held
	always @(posedge clk_i)
	begin
		if (!hold_i)
			t <= t + 10'h1;
	end
	// reference clock range
	// 15.6 MHz, 7.8 MHz, 0.98 MHz and 0.49 MHz clocks; data pins toggle often
	assign pin_o = {t[7], t[6], t[5] ^ t[0], t[4] ^ t[1], t[3], t[2]};
endmodule // pin_partner
`default_nettype wire

/* File: tb/codec_pin_function_mux_tb_top.sv */
// Self-checking bench of the codec pin function mux
`timescale 1ns/1ps
`default_nettype none
module codec_pin_function_mux_tb_top;
	logic clk_i = 1'b0, rst_b_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
	logic pwrite_i = 1'b0, interface_select_pin_i = 1'b0, hold = 1'b1;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o, q;
	logic pready_o, pslverr_o, control_bus_spi_o, pll_ref_o, codec_clk_o;
	logic bit_clock_pin_o, bit_clock_pin_oe_o, word_clock_pin_o, e;
	logic word_clock_pin_oe_o, serial_out_multi_pin_o, gpio_in_o;
	logic serial_out_multi_pin_oe_o, mic_clock_multi_pin_o;
	logic mic_clock_multi_pin_oe_o, general_purpose_pin_o;
	logic general_purpose_pin_oe_o, core_bclk_o, core_wclk_o, core_sdin_o;
	logic core_mic_data_o, core_adc_wclk_o;
	logic [5:0] pp;
	logic [5:0] d1, d2, d3;
	logic [3:0] cnt = 4'h0, dc;
	int failures = 0, checked = 0;
	// A pin the design drives shows the design's level
	wire master_clock_pin_i = pp[0];
	wire bit_clock_pin_i = bit_clock_pin_oe_o ? bit_clock_pin_o : pp[1];
	wire word_clock_pin_i = word_clock_pin_oe_o ? word_clock_pin_o : pp[5];
	wire serial_in_multi_pin_i = pp[2];
	wire mic_data_multi_pin_i = pp[3];
	wire general_purpose_pin_i = general_purpose_pin_oe_o ?
		general_purpose_pin_o : pp[4];
	// Core side levels come from a free counter
	wire pll_clk_i = cnt[0];
	wire core_bclk_i = cnt[1];
	wire first_interrupt_output_i = cnt[2];
	wire core_wclk_i = cnt[3];
	wire core_sdout_i = cnt[1];
	wire core_mic_clk_i = cnt[2];
	wire [5:0] pv = {word_clock_pin_i, general_purpose_pin_i,
		mic_data_multi_pin_i, serial_in_multi_pin_i, bit_clock_pin_i,
		master_clock_pin_i};
	// Sources: pins 0 to 4, zero 5, core levels 6 to 9, word clock pin 10
	wire [10:0] sv = {d3[5], dc, 1'b0, d3[4:0]};
	wire [12:0] ov = {mic_clock_multi_pin_o, serial_out_multi_pin_o,
		core_wclk_o, word_clock_pin_o, general_purpose_pin_o,
		bit_clock_pin_o, gpio_in_o, core_adc_wclk_o, core_mic_data_o,
		core_sdin_o, core_bclk_o, codec_clk_o, pll_ref_o};
	codec_pin_function_mux u_codec_pin_function_mux (.*);
	pin_partner u_pin_partner (.clk_i(clk_i), .hold_i(hold), .pin_o(pp));
	initial
		forever
			#4 clk_i = ~clk_i;
	// Expected sources, delayed as the design's paths delay them
	always @(posedge clk_i)
	begin
		cnt <= cnt + 4'h1;
		dc <= cnt;
		d1 <= pv;
		d2 <= d1;
		d3 <= d2;
	end
	task automatic check(input string nm, input logic [31:0] s,
		input logic [31:0] x);
		checked++;
		if (s !== x)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// One APB transfer; access lasts until pready, bounded
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do
			@(posedge clk_i);
		while (pready_o !== 1'b1 && ++n < 40);
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (n >= 40)
		begin
			failures++;
			end_of_test();
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x,
		input logic xe);
		apb(1'b0, a, 32'h0);
		check("prdata", q, x);
		check("pslverr", e, xe);
	endtask
	// Status word; the gpio level bit is the pin three edges back
	task automatic status(input logic [3:0] x);
		apb(1'b0, 12'h01c, 32'h0);
		check("status", {q[31:5], q[3:0]}, {27'h0, x});
		check("status_gpio", q[4], d3[4]);
	endtask
	// Compare one routed output with its source for twenty cycles
	task automatic follow(input int k, input int s);
		repeat (6)
			@(posedge clk_i);
		repeat (20)
		begin
			@(negedge clk_i);
			check("route", ov[k], sv[s]);
		end
	endtask
	// Reset values, writable bits and the unmapped slot
	task automatic t_regs();
		for (logic [11:0] a = 12'h000; a < 12'h01c; a += 12'h004)
		begin
			rd(a, 32'h0, 1'b0);
			apb(1'b1, a, 32'hffff_ffff);
			rd(a, (a == 12'h008 || a == 12'h00c || a == 12'h018) ?
				32'h1 : 32'h3, 1'b0);
		end
		apb(1'b1, 12'h020, 32'hffff_ffff);
		rd(12'h020, 32'h0, 1'b1);
	endtask
	// Strap picks the control bus; register writes cannot move it
	task automatic t_strap();
		for (int v = 1; v >= 0; v--)
		begin
			interface_select_pin_i <= v[0];
			apb(1'b1, 12'h01c, 32'hffff_ffff);
			repeat (4)
				@(negedge clk_i);
			check("spi", control_bus_spi_o, v[0]);
			status({3'h0, v[0]});
		end
	endtask
	// Clock sources; the bit clock pin serves three users at once
	task automatic t_clk();
		apb(1'b1, 12'h008, 32'h0);
		apb(1'b1, 12'h010, 32'h0);
		apb(1'b1, 12'h014, 32'h0);
		for (int s = 0; s < 4; s++)
		begin
			apb(1'b1, 12'h000, 32'(s));
			follow(0, (s == 3) ? 4 : s);
		end
		follow(3, 2);
		// pin or PLL, direct pin first
		for (int c = 0; c < 4; c++)
		begin
			apb(1'b1, 12'h004, 32'(c));
			follow(1, (c == 3) ? 8 - 2 : (c == 2) ? 4 : c);
		end
		apb(1'b1, 12'h000, 32'h1);
		apb(1'b1, 12'h004, 32'h1);
		for (int k = 0; k < 3; k++)
			follow(k, 1);
		// Word clock pin driven out, then read back in
		follow(9, 9);
		follow(10, 9);
		follow(11, 7);
		follow(12, 8);
		apb(1'b1, 12'h00c, 32'h0);
		follow(10, 10);
		follow(9, 5);
		check("wclk_oe", word_clock_pin_oe_o, 1'b0);
		apb(1'b1, 12'h000, 32'h2);
		follow(3, 5);
	endtask
	// General purpose pin functions and exclusive owners
	task automatic t_gpio();
		apb(1'b1, 12'h014, 32'h1);
		apb(1'b1, 12'h018, 32'h1);
		repeat (3)
			@(negedge clk_i);
		check("gpio_oe", general_purpose_pin_oe_o, 1'b1);
		check("gpio", general_purpose_pin_o, 1'b1);
		apb(1'b1, 12'h004, 32'h2);
		follow(1, 5);
		status(4'h6);
		apb(1'b1, 12'h014, 32'h2);
		follow(8, 8);
		apb(1'b1, 12'h010, 32'h2);
		follow(5, 4);
		check("gpio_oe", general_purpose_pin_oe_o, 1'b0);
		apb(1'b1, 12'h010, 32'h1);
		follow(5, 3);
		follow(4, 5);
		apb(1'b1, 12'h014, 32'h0);
		follow(6, 4);
	endtask
	// A reset in mid-run returns the pins to their defaults
	task automatic t_reset();
		apb(1'b1, 12'h008, 32'h1);
		apb(1'b1, 12'h014, 32'h1);
		follow(7, 7);
		// Reset is driven on the rising edge like every other input
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		repeat (2)
			@(posedge clk_i);
		rst_b_i <= 1'b1;
		@(negedge clk_i);
		check("bclk_oe", bit_clock_pin_oe_o, 1'b0);
		check("gpio_oe", general_purpose_pin_oe_o, 1'b0);
		check("sout_oe", serial_out_multi_pin_oe_o, 1'b0);
		@(negedge clk_i);
		check("sout_oe", serial_out_multi_pin_oe_o, 1'b1);
		check("mclk_oe", mic_clock_multi_pin_oe_o, 1'b1);
		check("wclk_oe", word_clock_pin_oe_o, 1'b0);
		check("gpio_oe", general_purpose_pin_oe_o, 1'b0);
		rd(12'h008, 32'h0, 1'b0);
		follow(1, 0);
	endtask
	initial
	begin
		repeat (8)
			@(posedge clk_i);
		rst_b_i <= 1'b1;
		hold <= 1'b0;
		t_regs();
		t_strap();
		t_clk();
		t_gpio();
		t_reset();
		end_of_test();
	end
endmodule // codec_pin_function_mux_tb_top
`default_nettype wire
